// ==== logic/backlight_mode_control.v ====
`timescale 1ns/1ps
`include "backlight_regs.vh"
module backlight_mode_control #(
    parameter SOFT_START_CYCLES = `SOFT_START_CYC,
    parameter SAMPLE_SHORT_CYCLES = `SAMPLE_SHORT_CYC,
    parameter SAMPLE_LONG_CYCLES = `SAMPLE_LONG_CYC
) (
    // clock and reset
    input wire CLK_I,
    input wire NRST_I,
    // wishbone slave
    input wire [3:0] ADR_I,
    input wire [31:0] DAT_I,
    input wire [3:0] SEL_I,
    input wire WE_I,
    input wire STB_I,
    input wire CYC_I,
    output reg [31:0] DAT_O,
    output reg ACK_O,
    // board pins, asynchronous
    input wire CHIP_ACTIVATE_PIN_I,
    input wire AUTO_DIMMING_ENABLE_PIN_I,
    input wire FORCED_FULL_LIGHT_PIN_I,
    input wire SAMPLE_PERIOD_SELECT_I,
    // level from the on-chip ambient dimming logic
    input wire [6:0] AUTO_LEVEL_I,
    // mode outputs
    output reg [2:0] STATE_O,
    output reg [6:0] LED_LEVEL_O,
    output reg SOFT_START_DONE_O,
    output reg SAMPLE_TICK_O
);
    // ==========================================================
    // pin synchronisation
    wire [3:0] pins_sync;
    wire activate;
    wire dim_pin;
    wire full_pin;
    wire period_pin;

    pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .async_i({SAMPLE_PERIOD_SELECT_I, FORCED_FULL_LIGHT_PIN_I,
                  AUTO_DIMMING_ENABLE_PIN_I, CHIP_ACTIVATE_PIN_I}),
        .sync_o(pins_sync)
    );
    assign activate = pins_sync[0];
    assign dim_pin = pins_sync[1];
    assign full_pin = pins_sync[2];
    assign period_pin = pins_sync[3];

    // ==========================================================
    // register file
    reg fixed_level_select_bit_reg;
    reg auto_dimming_enable_bit_reg;
    reg [6:0] fixed_level_reg;
    wire bus_req;
    wire bus_wr;

    assign bus_req = CYC_I & STB_I & ~ACK_O;
    assign bus_wr = bus_req & WE_I & SEL_I[0];

    // registers only load while reset is high; a low reset clears the control bits and sets the level to peak
    always @(posedge CLK_I) begin
        if (!NRST_I) begin
            fixed_level_select_bit_reg <= 1'b0;
            auto_dimming_enable_bit_reg <= 1'b0;
            fixed_level_reg <= `LEVEL_RESET;
        end else if (bus_wr) begin
            case (ADR_I)
                `ADDR_CTRL: begin
                    fixed_level_select_bit_reg <= DAT_I[`CTRL_FIXED_BIT];
                    auto_dimming_enable_bit_reg <= DAT_I[`CTRL_DIM_BIT];
                end
                `ADDR_LEVEL: begin
                    // seven bits hold 0..127, so peak is the ceiling
                    fixed_level_reg <= DAT_I[6:0];
                end
                default: begin
                    fixed_level_reg <= fixed_level_reg;
                end
            endcase
        end
    end

    // ==========================================================
    // soft start and mode selection
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [31:0] ss_count_reg;
    reg ss_done_reg;
    wire dim_effective;
    reg [2:0] run_sel;

    // dimming is on if either source asks for it
    assign dim_effective = dim_pin | auto_dimming_enable_bit_reg;

    // priority: full light, then fixed, then auto, else off
    always @* begin
        if (full_pin) begin
            run_sel = `ST_MAX;
        end else if (fixed_level_select_bit_reg) begin
            run_sel = `ST_FIXED;
        end else if (dim_effective) begin
            run_sel = `ST_AUTO;
        end else begin
            run_sel = `ST_OFF;
        end
    end

    // next state; activate low wins over everything
    always @* begin
        state_next = state_reg;
        if (!activate) begin
            state_next = `ST_STANDBY;
        end else begin
            case (state_reg)
                `ST_STANDBY: begin
                    state_next = `ST_SOFTSTART;
                end
                `ST_SOFTSTART: begin
                    // lighting choice held back until soft start ends
                    if (ss_done_reg) begin
                        state_next = run_sel;
                    end
                end
                `ST_OFF, `ST_MAX, `ST_AUTO, `ST_FIXED: begin
                    state_next = run_sel;
                end
                default: begin
                    state_next = `ST_STANDBY;
                end
            endcase
        end
    end

    // state register and soft-start counter; done rises one cycle before the
    // state leaves, so soft start lasts exactly SOFT_START_CYCLES cycles
    always @(posedge CLK_I) begin
        if (!NRST_I) begin
            state_reg <= `ST_STANDBY;
            ss_count_reg <= 32'h0000_0000;
            ss_done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_next != `ST_SOFTSTART) begin
                ss_count_reg <= 32'h0000_0000;
                ss_done_reg <= (state_next != `ST_STANDBY) ? ss_done_reg : 1'b0;
            end else if (ss_count_reg >= SOFT_START_CYCLES - 1) begin
                ss_done_reg <= 1'b1;
            end else begin
                ss_count_reg <= ss_count_reg + 32'h0000_0001;
            end
        end
    end

    // ==========================================================
    // brightness sampling period
    reg [31:0] samp_count_reg;
    wire [31:0] samp_limit;

    // pin high (or floating with pull-up) is the short period
    assign samp_limit = period_pin ? SAMPLE_SHORT_CYCLES : SAMPLE_LONG_CYCLES;

    // counter runs only outside standby; restarts when it reaches the period
    always @(posedge CLK_I) begin
        if (!NRST_I) begin
            samp_count_reg <= 32'h0000_0000;
            SAMPLE_TICK_O <= 1'b0;
        end else if (state_reg == `ST_STANDBY) begin
            samp_count_reg <= 32'h0000_0000;
            SAMPLE_TICK_O <= 1'b0;
        end else if (samp_count_reg >= samp_limit - 1) begin
            samp_count_reg <= 32'h0000_0000;
            SAMPLE_TICK_O <= 1'b1;
        end else begin
            samp_count_reg <= samp_count_reg + 32'h0000_0001;
            SAMPLE_TICK_O <= 1'b0;
        end
    end

    // ==========================================================
    // registered outputs
    always @(posedge CLK_I) begin
        if (!NRST_I) begin
            STATE_O <= `ST_STANDBY;
            LED_LEVEL_O <= 7'h00;
            SOFT_START_DONE_O <= 1'b0;
        end else begin
            STATE_O <= state_reg;
            SOFT_START_DONE_O <= ss_done_reg;
            case (state_reg)
                `ST_MAX: begin
                    LED_LEVEL_O <= `LEVEL_PEAK;
                end
                `ST_FIXED: begin
                    LED_LEVEL_O <= fixed_level_reg;
                end
                `ST_AUTO: begin
                    LED_LEVEL_O <= AUTO_LEVEL_I;
                end
                default: begin
                    // standby, soft start and off keep the LEDs dark
                    LED_LEVEL_O <= 7'h00;
                end
            endcase
        end
    end

    // ==========================================================
    // wishbone answer: one wait state, unmapped reads give zero
    always @(posedge CLK_I) begin
        if (!NRST_I) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else begin
            ACK_O <= bus_req;
            if (bus_req && !WE_I) begin
                case (ADR_I)
                    `ADDR_CTRL: begin
                        DAT_O <= {30'h0000_0000, auto_dimming_enable_bit_reg,
                                  fixed_level_select_bit_reg};
                    end
                    `ADDR_LEVEL: begin
                        DAT_O <= {25'h000_0000, fixed_level_reg};
                    end
                    `ADDR_STATUS: begin
                        DAT_O <= {25'h000_0000, SAMPLE_TICK_O, dim_effective,
                                  period_pin, ss_done_reg, state_reg};
                    end
                    default: begin
                        DAT_O <= 32'h0000_0000;
                    end
                endcase
            end else begin
                DAT_O <= 32'h0000_0000;
            end
        end
    end
endmodule

// ==== logic/backlight_regs.vh ====
`ifndef BACKLIGHT_REGS_VH
`define BACKLIGHT_REGS_VH

// ==========================================================
// register byte offsets
`define ADDR_CTRL 4'h0
`define ADDR_LEVEL 4'h4
`define ADDR_STATUS 4'h8

// ==========================================================
// field positions
`define CTRL_FIXED_BIT 0
`define CTRL_DIM_BIT 1
`define STAT_STATE_LSB 0
`define STAT_STATE_MSB 2
`define STAT_SS_DONE_BIT 3
`define STAT_PERIOD_BIT 4
`define STAT_DIM_BIT 5
`define STAT_TICK_BIT 6

// ==========================================================
// reset values and full-light peak level
`define CTRL_RESET 2'h0
`define LEVEL_RESET 7'h7f
`define LEVEL_PEAK 7'h7f

// ==========================================================
// operating states
`define ST_STANDBY 3'h0
`define ST_SOFTSTART 3'h1
`define ST_OFF 3'h2
`define ST_MAX 3'h3
`define ST_AUTO 3'h4
`define ST_FIXED 3'h5

// ==========================================================
// timing
`define CLK_KHZ 250000
`define SAMPLE_SHORT_MS 655
`define SAMPLE_LONG_MS 1310
`define SOFT_START_US 1000
`define SAMPLE_SHORT_CYC (`SAMPLE_SHORT_MS * `CLK_KHZ)
`define SAMPLE_LONG_CYC (`SAMPLE_LONG_MS * `CLK_KHZ)
`define SOFT_START_CYC ((`SOFT_START_US * `CLK_KHZ) / 1000)
`endif

// ==== logic/pin_sync.v ====
`timescale 1ns/1ps
// two-flop synchroniser for a group of asynchronous pins
module pin_sync #(
    parameter WIDTH = 4
) (
    // clock and reset
    input wire clk_i,
    input wire nrst_i,
    // pins
    input wire [WIDTH-1:0] async_i,
    // synchronised level
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    // first stage feeds only the second stage
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end
    assign sync_o = sync_reg;
endmodule

// ==== test/backlight_mode_control_assertions.sv ====
`timescale 1ns/1ps
// ====
// port-level checks for the mode logic
module backlight_mode_control_checker #(
    parameter SOFT_START_CYCLES = 8,
    parameter SAMPLE_SHORT_CYCLES = 20,
    parameter SAMPLE_LONG_CYCLES = 40
) (
    // clock and reset
    input wire CLK_I,
    input wire NRST_I,
    // bus
    input wire CYC_I,
    input wire STB_I,
    input wire ACK_O,
    // pins
    input wire CHIP_ACTIVATE_PIN_I,
    input wire AUTO_DIMMING_ENABLE_PIN_I,
    input wire FORCED_FULL_LIGHT_PIN_I,
    input wire SAMPLE_PERIOD_SELECT_I,
    input wire [6:0] AUTO_LEVEL_I,
    // outputs
    input wire [2:0] STATE_O,
    input wire [6:0] LED_LEVEL_O,
    input wire SAMPLE_TICK_O
);
    reg [31:0] ss_cnt_reg;
    reg [31:0] gap_reg;
    reg seen_reg;
    // soft-start length and tick spacing; first tick after standby is not judged
    always @(posedge CLK_I) begin
        ss_cnt_reg <= (STATE_O == 3'h1) ? ss_cnt_reg + 32'h1 : 32'h0;
        gap_reg <= SAMPLE_TICK_O ? 32'h0 : gap_reg + 32'h1;
        seen_reg <= NRST_I && (STATE_O != 3'h0) && (seen_reg || SAMPLE_TICK_O);
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // ====
    // assertions
    AST_RESET_CLEAR: assert property ($rose(NRST_I) |-> STATE_O == 3'h0 && !ACK_O)
        else $error("outputs not clear after reset");
    AST_ACK_PULSE: assert property (ACK_O |-> $past(CYC_I && STB_I) ##1 !ACK_O)
        else $error("ack without request or too long");
    AST_STANDBY_HOLD: assert property (!CHIP_ACTIVATE_PIN_I [*4] |=>
        STATE_O == 3'h0 && LED_LEVEL_O == 7'h00) else $error("not in standby");
    AST_SOFT_START_LEN: assert property (STATE_O == 3'h1 ##1 STATE_O > 3'h1 |->
        ss_cnt_reg == SOFT_START_CYCLES) else $error("soft start length wrong");
    AST_MAX_LEVEL: assert property (STATE_O == 3'h3 |-> LED_LEVEL_O == 7'h7f)
        else $error("full light not at peak");
    AST_FULL_PRIORITY: assert property ((CHIP_ACTIVATE_PIN_I
        && FORCED_FULL_LIGHT_PIN_I) [*4] ##0 STATE_O > 3'h1 |=> STATE_O == 3'h3)
        else $error("full light not taken");
    AST_AUTO_LEVEL: assert property (STATE_O == 3'h4 |->
        LED_LEVEL_O == $past(AUTO_LEVEL_I)) else $error("auto level not passed");
    AST_DARK_LEVEL: assert property (STATE_O inside {3'h0, 3'h1, 3'h2} |->
        LED_LEVEL_O == 7'h00) else $error("led lit while dark");
    AST_DIM_OR: assert property ((CHIP_ACTIVATE_PIN_I && AUTO_DIMMING_ENABLE_PIN_I
        && !FORCED_FULL_LIGHT_PIN_I) [*4] ##0 STATE_O > 3'h1 |=> STATE_O inside {3'h4, 3'h5})
        else $error("dimming pin ignored");
    AST_TICK_GAP: assert property (seen_reg && SAMPLE_TICK_O |-> gap_reg ==
        (SAMPLE_PERIOD_SELECT_I ? SAMPLE_SHORT_CYCLES - 1 : SAMPLE_LONG_CYCLES - 1))
        else $error("sample tick spacing wrong");
endmodule
bind backlight_mode_control backlight_mode_control_checker #(
    .SOFT_START_CYCLES(SOFT_START_CYCLES), .SAMPLE_SHORT_CYCLES(SAMPLE_SHORT_CYCLES),
    .SAMPLE_LONG_CYCLES(SAMPLE_LONG_CYCLES)
) backlight_mode_control_checker_inst (.CLK_I(CLK_I), .NRST_I(NRST_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .ACK_O(ACK_O), .CHIP_ACTIVATE_PIN_I(CHIP_ACTIVATE_PIN_I),
    .AUTO_DIMMING_ENABLE_PIN_I(AUTO_DIMMING_ENABLE_PIN_I),
    .FORCED_FULL_LIGHT_PIN_I(FORCED_FULL_LIGHT_PIN_I),
    .SAMPLE_PERIOD_SELECT_I(SAMPLE_PERIOD_SELECT_I), .AUTO_LEVEL_I(AUTO_LEVEL_I),
    .STATE_O(STATE_O), .LED_LEVEL_O(LED_LEVEL_O), .SAMPLE_TICK_O(SAMPLE_TICK_O));

// ==== test/wb_host.sv ====
`timescale 1ns/1ps
// ====
// classic wishbone master standing in for the bus host
module wb_host (
    // clock
    input wire clk_i,
    // bus
    output logic cyc_o = 1'b0,
    output logic stb_o = 1'b0,
    output logic we_o = 1'b0,
    output logic [3:0] adr_o = 4'h0,
    output logic [3:0] sel_o = 4'h0,
    output logic [31:0] dat_o = 32'h0,
    input wire ack_i,
    input wire [31:0] dat_i
);
    // one cycle; request held until ack is seen at an edge, then released
    task xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
              input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        {cyc_o, stb_o} <= 2'b00;
        dat_o <= ~d; // released lines do not keep the old value
    endtask
endmodule

// ==== test/backlight_mode_control_test.sv ====
`timescale 1ns/1ps
`include "backlight_regs.vh"
// ====
// self-checking bench for the mode logic
module backlight_mode_control_test;
    localparam SS = 8;
    localparam SH = 20;
    localparam LG = 40;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic act = 1'b0, dim = 1'b0, full = 1'b0, per = 1'b1;
    logic cyc, stb, we, ack, tick, done;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, q;
    logic [6:0] auto = 7'h00, led, lvl;
    logic [2:0] st;
    logic [9:0] want;
    logic [1:0] bits;
    int fails = 0, checks = 0, g;
    // 250 MHz
    always #2 clk = ~clk;
    wb_host wb_host_inst (.clk_i(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .ack_i(ack), .dat_i(rdat));
    backlight_mode_control #(.SOFT_START_CYCLES(SS), .SAMPLE_SHORT_CYCLES(SH),
        .SAMPLE_LONG_CYCLES(LG)) backlight_mode_control_inst (.CLK_I(clk), .NRST_I(nrst),
        .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel), .WE_I(we), .STB_I(stb), .CYC_I(cyc),
        .DAT_O(rdat), .ACK_O(ack), .CHIP_ACTIVATE_PIN_I(act), .AUTO_DIMMING_ENABLE_PIN_I(dim),
        .FORCED_FULL_LIGHT_PIN_I(full), .SAMPLE_PERIOD_SELECT_I(per), .AUTO_LEVEL_I(auto),
        .STATE_O(st), .LED_LEVEL_O(led), .SOFT_START_DONE_O(done), .SAMPLE_TICK_O(tick));
    // ====
    // helpers
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task rd_chk(input logic [3:0] a, input logic [31:0] e);
        wb_host_inst.xfer(1'b0, a, 32'h0, 4'hf, q);
        chk(q, e);
    endtask
    // edges between two ticks, less one; the first tick only starts the count
    task meas(output int n);
        repeat (2) begin
            n = 0;
            @(posedge clk);
            while (tick !== 1'b1 && n < 100) begin
                @(posedge clk);
                n++;
            end
        end
    endtask
    // priority: full light, then fixed bit, then either dimming enable, else off
    function logic [9:0] exp_mode(input logic f, input logic x, input logic d);
        if (f) return {`ST_MAX, `LEVEL_PEAK};
        if (x) return {`ST_FIXED, lvl};
        return d ? {`ST_AUTO, auto} : {`ST_OFF, 7'h00};
    endfunction
    // ====
    // main sequence
    initial begin
        void'($urandom(96));
        repeat (20) @(posedge clk); // reset held until the supply is up
        nrst <= 1'b1;
        rd_chk(`ADDR_CTRL, 32'h0);
        rd_chk(`ADDR_LEVEL, 32'h7f);
        rd_chk(4'hc, 32'h0);
        // lane 0 off, so the write is dropped
        wb_host_inst.xfer(1'b1, `ADDR_LEVEL, 32'h0000_0011, 4'he, q);
        rd_chk(`ADDR_LEVEL, 32'h7f);
        lvl = 7'($urandom_range(126, 1));
        wb_host_inst.xfer(1'b1, `ADDR_LEVEL, {25'h0, lvl}, 4'hf, q);
        wb_host_inst.xfer(1'b1, `ADDR_CTRL, 32'h1, 4'hf, q);
        act <= 1'b1;
        repeat (6) @(posedge clk);
        chk({st, led, done}, {`ST_SOFTSTART, 7'h00, 1'b0});
        repeat (SS + 6) @(posedge clk);
        chk({st, led, done}, {`ST_FIXED, lvl, 1'b1});
        // every full-light pin, dimming pin and control bit combination, random ambient level each time
        for (int i = 0; i < 16; i++) begin
            bits = i[1:0];
            {full, dim} <= i[3:2];
            auto <= 7'($urandom);
            wb_host_inst.xfer(1'b1, `ADDR_CTRL, {30'h0, bits}, 4'hf, q);
            repeat (6) @(posedge clk);
            want = exp_mode(full, bits[0], dim | bits[1]);
            chk({st, led, done}, {want, 1'b1});
        end
        act <= 1'b0;
        repeat (6) @(posedge clk);
        chk({st, led, done}, 11'h000);
        // period pin moved only in standby so the count starts clean
        for (int p = 0; p < 2; p++) begin
            {act, per} <= {1'b1, p[0]};
            meas(g);
            chk(g, (p ? SH : LG) - 1);
            act <= 1'b0;
            repeat (6) @(posedge clk);
        end
        rd_chk(`ADDR_STATUS, {26'h0, dim | bits[1], per, 4'h0});
        // second reset in mid-run clears the control bits and sets the level back to peak
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(`ADDR_CTRL, 32'h0);
        rd_chk(`ADDR_LEVEL, 32'h7f);
        close_out();
    end
    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule
